// [bench/rsq_reset_seq_bench.sv]
// Self-checking bench for the system reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rsq_reset_seq_bench;
  import rsq_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reset_pin_n, busy, bus_wr, bus_rd, go, glitch;
  logic [7:0] bus_addr = 8'h00;
  logic [15:0] bus_wdata = 16'h0000;
  logic [15:0] bus_rdata;
  logic [19:0] vec_addr, pc;
  logic vec_rd, pc_load, cpu_run, unit_reset_n, ram_retain, osc_enable;
  logic [7:0] vec_data = 8'h00;
  logic [7:0] port_out, port_oe_n, program_status_word, pulse_width_control;
  logic address_strobe_out, address_strobe_oe_n, pwm0_out, pwm1_out, pwm_oe_n;
  logic tx_out, tx_oe_n;
  logic [7:0] lo_byte = 8'h34;
  logic [7:0] hi_byte = 8'h12;
  int num_errors = 0;
  int n_compared = 0;
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    go = 1'b0;
    glitch = 1'b0;
  end
  always #2 clk = ~clk;

  rsq_reset_seq rsq_reset_seq_inst (.clk(clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .vec_addr(vec_addr), .vec_rd(vec_rd), .vec_data(vec_data),
    .pc(pc), .pc_load(pc_load), .cpu_run(cpu_run), .unit_reset_n(unit_reset_n),
    .ram_retain(ram_retain), .osc_enable(osc_enable), .port_out(port_out),
    .port_oe_n(port_oe_n), .address_strobe_out(address_strobe_out),
    .address_strobe_oe_n(address_strobe_oe_n), .pwm0_out(pwm0_out), .pwm1_out(pwm1_out),
    .pwm_oe_n(pwm_oe_n), .tx_out(tx_out), .tx_oe_n(tx_oe_n),
    .program_status_word(program_status_word), .pulse_width_control(pulse_width_control));

  rsq_reset_source rsq_reset_source_inst (.clk(clk), .go(go), .glitch(glitch),
    .osc_enable(osc_enable), .reset_pin_n(reset_pin_n), .busy(busy));

  // Vector memory, byte valid the cycle after the strobe
  always @(posedge clk) begin
    vec_data <= vec_rd ? (vec_addr == 20'h00001 ? hi_byte : lo_byte) : ~vec_data;
  end

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timeout(input string what);
    num_errors++;
    $display("Error %s expected done seen timeout", what);
    test_done;
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic read_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk(what, {4'h0, exp}, {4'h0, bus_rdata});
  endtask

  task automatic supervisor(input logic short_pulse);
    @(posedge clk);
    go <= 1'b1;
    glitch <= short_pulse;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask

  task automatic wait_pin;
    int k;
    for (k = 0; k < 4000 && (reset_pin_n !== 1'b1 || busy !== 1'b0); k++) step;
    if (k == 4000) timeout("pin release");
  endtask

  task automatic pins_chk(input logic in_rst);
    chk("port oe", 20'h000FF, port_oe_n);
    chk("strobe oe", in_rst, address_strobe_oe_n);
    chk("pwm oe", in_rst, pwm_oe_n);
    chk("tx oe", in_rst, tx_oe_n);
    chk("unit reset", !in_rst, unit_reset_n);
    if (!in_rst) chk("out levels", 0, {address_strobe_out, pwm0_out, pwm1_out, tx_out});
  endtask

  // Release, vector fetch and program counter load
  task automatic boot;
    int n;
    int k;
    wait_pin;
    for (n = 0; n < 100 && vec_rd !== 1'b1; n++) step;
    if (n == 100) timeout("vector strobe");
    chk("release delay", 1, n >= FILTER_CYC + 2 && n <= FILTER_CYC + 8);
    chk("vector lo addr", 20'h00000, vec_addr);
    step;
    chk("vector hi addr", 20'h00001, vec_addr);
    step;
    chk("pc load", 1, pc_load);
    for (k = 0; k < 8 && cpu_run !== 1'b1; k++) step;
    if (k == 8) timeout("cpu run");
    chk("pc", {4'h0, hi_byte, lo_byte}, pc);
    pins_chk(1'b0);
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_power_on;
    repeat (3) step;
    chk("run in reset", 0, cpu_run);
    chk("osc in reset", 1, osc_enable);
    pins_chk(1'b1);
    boot;
    chk("retain", 0, ram_retain);
    $display("power on test done");
  endtask

  task automatic t_reg_values;
    read_chk("psw", OFS_PSW, 16'h0002);
    read_chk("port dir", OFS_PORT_DIR, 16'h00FF);
    read_chk("func select", OFS_PORT_FSEL, 16'h0000);
    read_chk("pullup", OFS_PULLUP, 16'h0000);
    read_chk("capture ctrl", OFS_CAPCMP, 16'h0010);
    read_chk("pulse ctrl", OFS_PWMCTL, 16'h0005);
    read_chk("conv serial ctrl", OFS_PERCTL, 16'h0000);
    read_chk("unmapped", 8'hFF, 16'h0000);
    chk("port latch", RST_PORT_OUT, port_out);
    bus_write(OFS_COMPARE, 16'h5A3C);
    read_chk("compare", OFS_COMPARE, 16'h5A3C);
    chk("psw port", 20'h00002, program_status_word);
    chk("pulse port", 20'h00005, pulse_width_control);
    $display("register values test done");
  endtask

  task automatic t_glitch;
    bus_write(OFS_PSW, 16'h0055);
    supervisor(1'b1);
    wait_pin;
    repeat (FILTER_CYC + 8) step;
    chk("run after glitch", 1, cpu_run);
    chk("unit after glitch", 1, unit_reset_n);
    read_chk("psw kept", OFS_PSW, 16'h0055);
    $display("glitch test done");
  endtask

  task automatic t_standby(input logic [1:0] mode);
    int k;
    lo_byte <= lo_byte + 8'h11;
    hi_byte <= hi_byte ^ 8'hA5;
    bus_write(OFS_STANDBY, {14'h0000, mode});
    bus_write(OFS_PSW, 16'h0077);
    step;
    if (mode >= 2'd2) chk("osc stopped", 0, osc_enable);
    supervisor(1'b0);
    for (k = 0; k < 80 && unit_reset_n !== 1'b0; k++) step;
    if (k == 80) timeout("internal reset");
    step;
    chk("osc restart", 1, osc_enable);
    pins_chk(1'b1);
    read_chk("timer cleared", OFS_TIMER, RST_TIMER);
    boot;
    chk("retain", mode != 2'd0, ram_retain);
    read_chk("psw reset", OFS_PSW, 16'h0002);
    $display("standby mode %0d test done", mode);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_power_on;
    t_reg_values;
    t_glitch;
    t_standby(2'd3);
    t_standby(2'd2);
    t_standby(2'd1);
    t_standby(2'd0);
    test_done;
  end
endmodule
`default_nettype wire

// [bench/rsq_reset_source.sv]
// Behavioural reset supervisor that drives the reset pin
`timescale 1ns/1ps
`default_nettype none
module rsq_reset_source #(
  parameter int STAB_CYC = 40,
  parameter int GLITCH_CYC = 10
) (
  input wire logic clk,
  input wire logic go,
  input wire logic glitch,
  input wire logic osc_enable,
  output logic reset_pin_n,
  output logic busy
);
  int cnt = STAB_CYC;
  logic short_reg = 1'b0;
  initial reset_pin_n = 1'b0;
  // Full settling counted only while the oscillator runs; a glitch pulse counts down regardless
  always @(posedge clk) begin
    if (go) begin
      reset_pin_n <= 1'b0;
      short_reg <= glitch;
      cnt <= glitch ? GLITCH_CYC : STAB_CYC;
    end else if (cnt != 0) begin
      if (short_reg || osc_enable === 1'b1) cnt <= cnt - 1;
    end else begin
      reset_pin_n <= 1'b1;
    end
  end
  assign busy = (cnt != 0) || !reset_pin_n;
endmodule
`default_nettype wire

// [logic/rsq_noise_filter.sv]
// Delay filter that ignores short glitches on the reset pin
`timescale 1ns/1ps
`default_nettype none
module rsq_noise_filter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin_n,
  output logic filt_n
);
  import rsq_pkg::*;

  logic [FILTER_W-1:0] cnt_reg;
  logic [FILTER_W-1:0] cnt_next;
  logic filt_reg;
  logic filt_next;

  // ------------------------------------------------------------
  // Level must hold for the full delay before it is accepted
  // ------------------------------------------------------------
  always_comb begin
    cnt_next = '0;
    filt_next = filt_reg;
    if (pin_n != filt_reg) begin
      if (cnt_reg == FILTER_W'(FILTER_CYC - 1)) begin
        filt_next = pin_n; // RQ4
      end else begin
        cnt_next = cnt_reg + FILTER_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  assign filt_n = filt_reg;

  property p_filter_glitch;
    @(posedge clk) disable iff (!rstn)
      $fell(pin_n) && filt_reg ##1 pin_n |-> ##1 filt_reg;
  endproperty
  a_filter_glitch: assert property (p_filter_glitch) else $error("short low pulse passed"); // RQ4

endmodule
`default_nettype wire

// [logic/rsq_reset_seq.sv]
// System reset sequencer: reset filter, pin control, unit reset and vector fetch
`timescale 1ns/1ps
`default_nettype none
// Requirements behind the RQ tags
// RQ1: Low reset pin holds every unit in its defined reset state.
// RQ2: During reset every pin except supply and oscillator floats.
// RQ3: On release PC takes bytes 00000H and 00001H, top nibble zero, then runs.
// RQ4: Reset pin passes a delay filter so short low glitches are ignored.
// RQ5: At power-on the outside holds reset until the oscillator settles.
// RQ6: After release port pins stay floating inputs.
// RQ7: After release strobe, pulse outputs and transmit drive low; receive floats.
// RQ8: Reset sets status word 02H, directions FFH, select and pull-ups 00H.
// RQ9: Reset clears timer, capture control 10H, pulse control 05H, compares undefined.
// RQ10: Reset clears converter and serial controls; data registers stay undefined.
// RQ11: Retained state survives a reset that leaves a standby mode.
// RQ12: Reset restarts a stopped oscillator; outside holds it for settling.
// RQ13: Filtered reset is synchronised before the internal reset ends.
module rsq_reset_seq (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_pin_n,
  input wire logic [7:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  output logic [19:0] vec_addr,
  output logic vec_rd,
  input wire logic [7:0] vec_data,
  output logic [19:0] pc,
  output logic pc_load,
  output logic cpu_run,
  output logic unit_reset_n,
  output logic ram_retain,
  output logic osc_enable,
  output logic [7:0] port_out,
  output logic [7:0] port_oe_n,
  output logic address_strobe_out,
  output logic address_strobe_oe_n,
  output logic pwm0_out,
  output logic pwm1_out,
  output logic pwm_oe_n,
  output logic tx_out,
  output logic tx_oe_n,
  output logic [7:0] program_status_word,
  output logic [7:0] pulse_width_control
);
  import rsq_pkg::*;

  // ------------------------------------------------------------
  // Reset input path
  // ------------------------------------------------------------
  logic filt_n;
  logic sync_n;

  rsq_noise_filter u_filter (
    .clk(clk),
    .rstn(rstn),
    .pin_n(reset_pin_n),
    .filt_n(filt_n)
  );

  rsq_sync2 u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(filt_n),
    .q(sync_n)
  );

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  rsq_state_t state_reg;
  rsq_state_t state_next;
  logic [19:0] pc_reg;
  logic [19:0] pc_next;
  logic [7:0] vec_lo_reg;
  logic [7:0] vec_lo_next;
  logic retain_reg;
  logic retain_next;
  logic in_reset;
  logic [1:0] standby_reg;

  assign in_reset = (state_reg == ST_RESET);

  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    vec_lo_next = vec_lo_reg;
    retain_next = retain_reg;
    if (!sync_n) begin
      state_next = ST_RESET; // RQ13
      if (!in_reset) retain_next = (standby_reg != SB_NONE); // RQ11
    end else begin
      unique case (state_reg)
        ST_RESET: state_next = ST_VEC_LO;
        ST_VEC_LO: state_next = ST_VEC_HI;
        ST_VEC_HI: begin
          vec_lo_next = vec_data;
          state_next = ST_LOAD;
        end
        ST_LOAD: begin
          pc_next = {PC_UPPER_RST, vec_data, vec_lo_reg}; // RQ3
          state_next = ST_RUN;
        end
        ST_RUN: state_next = ST_RUN;
        default: state_next = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_RESET;
      pc_reg <= '0;
      vec_lo_reg <= '0;
      retain_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      vec_lo_reg <= vec_lo_next;
      retain_reg <= retain_next;
    end
  end

  assign vec_rd = (state_reg == ST_VEC_LO) || (state_reg == ST_VEC_HI);
  assign vec_addr = (state_reg == ST_VEC_HI) ? VEC_ADDR_HI : VEC_ADDR_LO;
  assign pc = pc_reg;
  assign pc_load = (state_reg == ST_LOAD);
  assign cpu_run = (state_reg == ST_RUN);
  assign unit_reset_n = !in_reset; // RQ1
  assign ram_retain = retain_reg;

  // ------------------------------------------------------------
  // Unit registers
  // ------------------------------------------------------------
  logic [7:0] psw_reg, psw_next;
  logic [7:0] dir_reg, dir_next;
  logic [7:0] fsel_reg, fsel_next;
  logic [7:0] pull_reg, pull_next;
  logic [15:0] timer_reg, timer_next;
  logic [7:0] capcmp_reg, capcmp_next;
  logic [7:0] pwmctl_reg, pwmctl_next;
  logic [7:0] perctl_reg, perctl_next;
  logic [7:0] pout_reg, pout_next;
  logic [1:0] standby_next;
  logic [15:0] compare_reg;
  logic [15:0] rdata_reg, rdata_next;
  logic wr_ok;

  assign wr_ok = bus_wr && !in_reset;

  always_comb begin
    psw_next = psw_reg;
    dir_next = dir_reg;
    fsel_next = fsel_reg;
    pull_next = pull_reg;
    timer_next = cpu_run ? timer_reg + 16'h0001 : timer_reg;
    capcmp_next = capcmp_reg;
    pwmctl_next = pwmctl_reg;
    perctl_next = perctl_reg;
    pout_next = pout_reg;
    standby_next = standby_reg;
    if (in_reset) begin
      psw_next = RST_PSW; // RQ8
      dir_next = RST_PORT_DIR; // RQ8
      fsel_next = RST_PORT_FSEL; // RQ8
      pull_next = RST_PULLUP; // RQ8
      timer_next = RST_TIMER; // RQ9
      capcmp_next = RST_CAPCMP; // RQ9
      pwmctl_next = RST_PWMCTL; // RQ9
      perctl_next = RST_PERCTL; // RQ10
      pout_next = RST_PORT_OUT;
      standby_next = SB_NONE;
    end else if (wr_ok) begin
      unique case (bus_addr)
        OFS_PSW: psw_next = bus_wdata[7:0];
        OFS_PORT_DIR: dir_next = bus_wdata[7:0];
        OFS_PORT_FSEL: fsel_next = bus_wdata[7:0];
        OFS_PULLUP: pull_next = bus_wdata[7:0];
        OFS_TIMER: timer_next = bus_wdata;
        OFS_CAPCMP: capcmp_next = bus_wdata[7:0];
        OFS_PWMCTL: pwmctl_next = bus_wdata[7:0];
        OFS_PERCTL: perctl_next = bus_wdata[7:0];
        OFS_STANDBY: standby_next = bus_wdata[1:0];
        OFS_PORT_OUT: pout_next = bus_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psw_reg <= RST_PSW;
      dir_reg <= RST_PORT_DIR;
      fsel_reg <= RST_PORT_FSEL;
      pull_reg <= RST_PULLUP;
      timer_reg <= RST_TIMER;
      capcmp_reg <= RST_CAPCMP;
      pwmctl_reg <= RST_PWMCTL;
      perctl_reg <= RST_PERCTL;
      pout_reg <= RST_PORT_OUT;
      standby_reg <= SB_NONE;
    end else begin
      psw_reg <= psw_next;
      dir_reg <= dir_next;
      fsel_reg <= fsel_next;
      pull_reg <= pull_next;
      timer_reg <= timer_next;
      capcmp_reg <= capcmp_next;
      pwmctl_reg <= pwmctl_next;
      perctl_reg <= perctl_next;
      pout_reg <= pout_next;
      standby_reg <= standby_next;
    end
  end

  // Compare value has no reset value
  always_ff @(posedge clk) begin
    if (wr_ok && bus_addr == OFS_COMPARE) compare_reg <= bus_wdata; // RQ9
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (bus_rd) begin
      unique case (bus_addr)
        OFS_PSW: rdata_next = {8'h00, psw_reg};
        OFS_PORT_DIR: rdata_next = {8'h00, dir_reg};
        OFS_PORT_FSEL: rdata_next = {8'h00, fsel_reg};
        OFS_PULLUP: rdata_next = {8'h00, pull_reg};
        OFS_TIMER: rdata_next = timer_reg;
        OFS_CAPCMP: rdata_next = {8'h00, capcmp_reg};
        OFS_PWMCTL: rdata_next = {8'h00, pwmctl_reg};
        OFS_PERCTL: rdata_next = {8'h00, perctl_reg};
        OFS_COMPARE: rdata_next = compare_reg;
        OFS_STANDBY: rdata_next = {14'h0000, standby_reg};
        OFS_STATUS: rdata_next = {11'h000, retain_reg, osc_enable, state_reg};
        OFS_PORT_OUT: rdata_next = {8'h00, pout_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  assign port_out = pout_reg;
  assign port_oe_n = in_reset ? 8'hFF : dir_reg; // RQ2 RQ6
  assign address_strobe_out = 1'b0; // RQ7
  assign address_strobe_oe_n = in_reset; // RQ2 RQ7
  assign pwm0_out = 1'b0;
  assign pwm1_out = 1'b0;
  assign pwm_oe_n = in_reset; // RQ7
  assign tx_out = 1'b0;
  assign tx_oe_n = in_reset; // RQ7
  assign osc_enable = in_reset || !(standby_reg == SB_STOP || standby_reg == SB_IDLE); // RQ12
  assign program_status_word = psw_reg;
  assign pulse_width_control = pwmctl_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_unit_reset;
    @(posedge clk) disable iff (!rstn)
      !sync_n |=> in_reset && !unit_reset_n;
  endproperty
  a_unit_reset: assert property (p_unit_reset) else $error("pin low but no unit reset"); // RQ1
  property p_pins_float;
    @(posedge clk) disable iff (!rstn)
      in_reset |-> port_oe_n == 8'hFF && address_strobe_oe_n && pwm_oe_n && tx_oe_n;
  endproperty
  a_pins_float: assert property (p_pins_float) else $error("pin driven during reset"); // RQ2
  property p_vector_seq;
    @(posedge clk) disable iff (!rstn)
      in_reset ##1 state_reg == ST_VEC_LO ##0 sync_n [*3] |->
        pc_load && $past(vec_rd, 2) && $past(vec_addr, 2) == VEC_ADDR_LO && $past(vec_rd)
        && $past(vec_addr) == VEC_ADDR_HI ##1 cpu_run;
  endproperty
  a_vector_seq: assert property (p_vector_seq) else $error("vector fetch out of order"); // RQ3
  property p_pc_value;
    @(posedge clk) disable iff (!rstn)
      pc_load && sync_n |=> pc == {PC_UPPER_RST, $past(vec_data), $past(vec_lo_reg)};
  endproperty
  a_pc_value: assert property (p_pc_value) else $error("pc not loaded from vector"); // RQ3
  property p_ports_input;
    @(posedge clk) disable iff (!rstn)
      $fell(in_reset) |-> port_oe_n == 8'hFF;
  endproperty
  a_ports_input: assert property (p_ports_input) else $error("port driven after release"); // RQ6
  property p_outputs_low;
    @(posedge clk) disable iff (!rstn)
      $fell(in_reset) |-> !address_strobe_oe_n && !address_strobe_out && !pwm_oe_n && !tx_out;
  endproperty
  a_outputs_low: assert property (p_outputs_low) else $error("outputs not low after release"); // RQ7
  property p_reset_values;
    @(posedge clk) disable iff (!rstn)
      in_reset ##1 in_reset |-> psw_reg == RST_PSW && dir_reg == RST_PORT_DIR
        && fsel_reg == RST_PORT_FSEL && pull_reg == RST_PULLUP;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("port reset value wrong"); // RQ8
  property p_timer_values;
    @(posedge clk) disable iff (!rstn)
      in_reset ##1 in_reset |-> timer_reg == RST_TIMER && capcmp_reg == RST_CAPCMP
        && pwmctl_reg == RST_PWMCTL && perctl_reg == RST_PERCTL;
  endproperty
  a_timer_values: assert property (p_timer_values) else $error("unit reset value wrong"); // RQ9 RQ10
  property p_retain;
    @(posedge clk) disable iff (!rstn)
      cpu_run && standby_reg != SB_NONE && !sync_n |=> ram_retain;
  endproperty
  a_retain: assert property (p_retain) else $error("standby exit lost retention"); // RQ11
  property p_osc_restart;
    @(posedge clk) disable iff (!rstn)
      standby_reg == SB_IDLE && !sync_n |=> osc_enable;
  endproperty
  a_osc_restart: assert property (p_osc_restart) else $error("oscillator not restarted"); // RQ12
  property p_sync_delay;
    @(posedge clk) disable iff (!rstn)
      $rose(filt_n) && in_reset |-> in_reset ##1 in_reset;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("reset left before sync"); // RQ13

endmodule
`default_nettype wire

// [logic/rsq_sync2.sv]
// Two-stage synchroniser for the filtered reset level
`timescale 1ns/1ps
`default_nettype none
module rsq_sync2 (
  input wire logic clk,
  input wire logic rstn,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic sync_reg;

  // ------------------------------------------------------------
  // First stage feeds only the second
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d; // RQ13
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule
`default_nettype wire

// [pkg/rsq_pkg.sv]
// Constants and types shared by the system reset sequencer
package rsq_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int FILTER_NS = 100;
  localparam int FILTER_CYC = (FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int FILTER_W = 8;

  // ------------------------------------------------------------
  // Reset vector
  // ------------------------------------------------------------
  localparam logic [19:0] VEC_ADDR_LO = 20'h00000;
  localparam logic [19:0] VEC_ADDR_HI = 20'h00001;
  localparam logic [3:0] PC_UPPER_RST = 4'h0;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_PSW = 8'h00;
  localparam logic [7:0] OFS_PORT_DIR = 8'h01;
  localparam logic [7:0] OFS_PORT_FSEL = 8'h02;
  localparam logic [7:0] OFS_PULLUP = 8'h03;
  localparam logic [7:0] OFS_TIMER = 8'h04;
  localparam logic [7:0] OFS_CAPCMP = 8'h05;
  localparam logic [7:0] OFS_PWMCTL = 8'h06;
  localparam logic [7:0] OFS_PERCTL = 8'h07;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_STANDBY = 8'h09;
  localparam logic [7:0] OFS_STATUS = 8'h0A;
  localparam logic [7:0] OFS_PORT_OUT = 8'h0B;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_PSW = 8'h02;
  localparam logic [7:0] RST_PORT_DIR = 8'hFF;
  localparam logic [7:0] RST_PORT_FSEL = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [15:0] RST_TIMER = 16'h0000;
  localparam logic [7:0] RST_CAPCMP = 8'h10;
  localparam logic [7:0] RST_PWMCTL = 8'h05;
  localparam logic [7:0] RST_PERCTL = 8'h00;
  localparam logic [7:0] RST_PORT_OUT = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_VEC_LO = 3'b001,
    ST_VEC_HI = 3'b010,
    ST_LOAD = 3'b011,
    ST_RUN = 3'b100
  } rsq_state_t;

  typedef enum logic [1:0] {
    SB_NONE = 2'b00,
    SB_HALT = 2'b01,
    SB_STOP = 2'b10,
    SB_IDLE = 2'b11
  } rsq_standby_t;

endpackage
